/* src/sie_defines.vh */
`ifndef SIE_DEFINES_VH
`define SIE_DEFINES_VH

// Clock rate and time units
`define SIE_CLK_MHZ 250
`define SIE_CYC_PER_MS (`SIE_CLK_MHZ * 1000)

// Lamp timing in milliseconds
`define SIE_FLASH_HALF_MS 250
`define SIE_RED_MS 500
`define SIE_BOOT_MS 200

// Register word addresses
`define SIE_ADDR_CTRL 2'h0
`define SIE_ADDR_CMD 2'h1
`define SIE_ADDR_STAT 2'h2

// Reset values
`define SIE_CTRL_RST 32'h00000000

// Control register fields
`define SIE_CTRL_MODE 1:0
`define SIE_CTRL_FEXIST 2
`define SIE_CTRL_FEN 3
`define SIE_CTRL_PROJ 4
`define SIE_CTRL_RFAULT 5
`define SIE_CTRL_MFAULT 6
`define SIE_CTRL_CBUSY 7
`define SIE_CTRL_NOFS 8
`define SIE_CTRL_CFG 23:16
`define SIE_CTRL_RESP 31:24

// Command register fields
`define SIE_CMD_STORE 0
`define SIE_CMD_LOAD 1
`define SIE_CMD_DONE 2

// Status register fields
`define SIE_STAT_STATE 2:0
`define SIE_STAT_REFUSED 3
`define SIE_STAT_LOCKED 4
`define SIE_STAT_PRESENT 5
`define SIE_STAT_LAMPS 15:8

// Operating modes
`define SIE_MODE_PROG 2'h0
`define SIE_MODE_RUN 2'h1
`define SIE_MODE_TEST 2'h2

`endif

/* src/sie_sync3.v */
module sie_sync3 #(
  parameter W = 2
) (
  input wire sys_clk_i,
  input wire nrst_i,
  input wire ce_i,
  input wire [W-1:0] async_i,
  output reg [W-1:0] sync_o
);

  reg [W-1:0] meta;
  reg [W-1:0] stage2;
  reg [W-1:0] stage3;
  integer i;

  // Each bit changes once stages two and three agree
  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      meta <= {W{1'b0}};
      stage2 <= {W{1'b0}};
      stage3 <= {W{1'b0}};
      sync_o <= {W{1'b0}};
    end else if (ce_i) begin
      meta <= async_i;
      stage2 <= meta;
      stage3 <= stage2;
      for (i = 0; i < W; i = i + 1) begin
        if (stage2[i] == stage3[i]) begin
          sync_o[i] <= stage3[i];
        end
      end
    end
  end

endmodule

/* src/sie_flash_div.v */
module sie_flash_div #(
  parameter CNT_W = 27,
  parameter [31:0] HALF_CYC = 32'h03B9ACA0
) (
  input wire sys_clk_i,
  input wire nrst_i,
  input wire ce_i,
  output reg flash_o
);

  localparam [31:0] HALF_LAST32 = HALF_CYC - 32'h1;

  reg [CNT_W-1:0] cnt;

  // Shared blink phase for all lamps
  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      cnt <= {CNT_W{1'b0}};
      flash_o <= 1'b0;
    end else if (ce_i) begin
      if (cnt == HALF_LAST32[CNT_W-1:0]) begin
        cnt <= {CNT_W{1'b0}};
        flash_o <= ~flash_o;
      end else begin
        cnt <= cnt + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

/* src/sie_lamp_encoder.v */
// The register offsets and the Avalon-MM slave port were chosen for this implementation.
`include "sie_defines.vh"

module sie_lamp_encoder #(
  parameter CNT_W = 27,
  parameter [31:0] FLASH_HALF_CYC = `SIE_FLASH_HALF_MS * `SIE_CYC_PER_MS,
  parameter [31:0] RED_CYC = `SIE_RED_MS * `SIE_CYC_PER_MS,
  parameter [31:0] BOOT_CYC = `SIE_BOOT_MS * `SIE_CYC_PER_MS
) (
  input wire sys_clk_i,
  input wire nrst_i,
  input wire ce_i,
  input wire [1:0] address_i,
  input wire read_i,
  input wire write_i,
  input wire [3:0] byteenable_i,
  input wire [31:0] writedata_i,
  output reg [31:0] readdata_o,
  output reg waitrequest_o,
  input wire card_lock_i,
  input wire card_present_i,
  output reg health_green_o,
  output reg health_red_o,
  output reg card_green_o,
  output reg card_red_o,
  output reg mode_green_o,
  output reg override_yellow_o,
  output reg link_green_o,
  output reg link_red_o,
  output reg self_reset_o
);

  localparam [2:0] ST_IDLE = 3'b000;
  localparam [2:0] ST_STORE = 3'b001;
  localparam [2:0] ST_LOAD = 3'b010;
  localparam [2:0] ST_RST_RED = 3'b011;
  localparam [2:0] ST_RST_BOOT = 3'b100;

  localparam [31:0] RED_LAST32 = RED_CYC - 32'h1;
  localparam [31:0] BOOT_LAST32 = BOOT_CYC - 32'h1;

  reg [31:0] ctrl;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [CNT_W-1:0] timer;
  reg refused;
  reg next_refused;
  reg next_health_green;
  reg next_health_red;
  reg next_card_green;
  reg next_card_red;
  reg next_mode_green;
  reg next_override_yellow;
  reg next_link_green;
  reg next_link_red;
  reg [31:0] next_readdata;
  reg [31:0] next_ctrl;
  reg [CNT_W-1:0] next_timer;
  integer i;

  wire flash;
  wire [1:0] pins_sync;
  wire card_locked;
  wire card_present;
  wire [7:0] lamp_vec;

  assign card_locked = pins_sync[0];
  assign card_present = pins_sync[1];

  // Lamp levels as shown on the panel, for status readback
  assign lamp_vec = {health_green_o, health_red_o, card_green_o,
    card_red_o, mode_green_o, override_yellow_o, link_green_o,
    link_red_o};

  sie_sync3 #(
    .W(2)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .async_i({card_present_i, card_lock_i}),
    .sync_o(pins_sync)
  );

  sie_flash_div #(
    .CNT_W(CNT_W),
    .HALF_CYC(FLASH_HALF_CYC)
  ) u_flash (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .flash_o(flash)
  );

  // Bus access completes in the cycle waitrequest is low
  wire acc_wr = write_i & ~waitrequest_o;
  wire wr_ctrl = acc_wr & (address_i == `SIE_ADDR_CTRL);
  wire wr_cmd = acc_wr & (address_i == `SIE_ADDR_CMD) & byteenable_i[0];
  wire wr_stat = acc_wr & (address_i == `SIE_ADDR_STAT) & byteenable_i[0];

  wire cmd_store = wr_cmd & writedata_i[`SIE_CMD_STORE];
  wire cmd_load = wr_cmd & writedata_i[`SIE_CMD_LOAD];
  wire cmd_done = wr_cmd & writedata_i[`SIE_CMD_DONE];

  wire [1:0] mode = ctrl[`SIE_CTRL_MODE];
  wire prog_mode = (mode == `SIE_MODE_PROG);
  wire major_fault = ctrl[`SIE_CTRL_MFAULT];
  wire any_fault = major_fault | ctrl[`SIE_CTRL_RFAULT];
  wire [7:0] cfg_cnt = ctrl[`SIE_CTRL_CFG];
  wire [7:0] resp_cnt = ctrl[`SIE_CTRL_RESP];

  wire store_ok = prog_mode & card_present & ~card_locked;
  wire load_ok = prog_mode & card_present;

  wire in_reset = (state == ST_RST_RED) | (state == ST_RST_BOOT);
  wire in_xfer = (state == ST_STORE) | (state == ST_LOAD);
  wire red_end = (timer == RED_LAST32[CNT_W-1:0]);
  wire boot_end = (timer == BOOT_LAST32[CNT_W-1:0]);

  // Sequencer
  always @* begin
    next_state = state;
    next_refused = refused;
    if (wr_stat & writedata_i[`SIE_STAT_REFUSED]) begin
      next_refused = 1'b0;
    end
    case (state)
      ST_IDLE: begin
        if (cmd_store) begin
          if (store_ok) begin
            next_state = ST_STORE;
          end else begin
            next_refused = 1'b1;
          end
        end else if (cmd_load) begin
          if (load_ok) begin
            next_state = ST_LOAD;
          end else begin
            next_refused = 1'b1;
          end
        end
      end
      ST_STORE: begin
        // New store or load requests are ignored until the end
        if (cmd_done) begin
          next_state = ST_RST_RED;
        end
      end
      ST_LOAD: begin
        if (cmd_done) begin
          next_state = ST_RST_RED;
        end
      end
      ST_RST_RED: begin
        if (red_end) begin
          next_state = ST_RST_BOOT;
        end
      end
      ST_RST_BOOT: begin
        if (boot_end) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Lamp encoding, self-reset blanking first except on health, then fault, then progress, then idle
  always @* begin
    next_health_green = 1'b0;
    next_health_red = 1'b0;
    next_card_green = 1'b0;
    next_card_red = 1'b0;
    next_mode_green = 1'b0;
    next_override_yellow = 1'b0;
    next_link_green = 1'b0;
    next_link_red = 1'b0;
    // Health lamp
    if (major_fault) begin
      next_health_red = 1'b1;
    end else if (any_fault) begin
      next_health_red = flash;
    end else begin
      case (state)
        ST_STORE: next_health_green = flash;
        ST_LOAD: next_health_green = flash;
        ST_RST_RED: next_health_red = 1'b1;
        ST_RST_BOOT: next_health_green = 1'b0;
        default: next_health_green = 1'b1;
      endcase
    end
    // Card activity lamp
    if (in_reset) begin
      next_card_green = 1'b0;
    end else if (ctrl[`SIE_CTRL_NOFS]) begin
      next_card_red = flash;
    end else if (in_xfer | ctrl[`SIE_CTRL_CBUSY]) begin
      next_card_green = flash;
    end else begin
      next_card_green = 1'b0;
    end
    // Mode lamp
    if (!in_reset) begin
      next_mode_green = (mode == `SIE_MODE_RUN);
    end
    // Override lamp
    if (in_reset) begin
      next_override_yellow = 1'b0;
    end else if (ctrl[`SIE_CTRL_FEN]) begin
      next_override_yellow = 1'b1;
    end else if (ctrl[`SIE_CTRL_FEXIST]) begin
      next_override_yellow = flash;
    end else begin
      next_override_yellow = 1'b0;
    end
    // Peripheral link lamp
    if (in_reset) begin
      next_link_red = 1'b0;
    end else if (any_fault) begin
      next_link_red = flash;
    end else if (!ctrl[`SIE_CTRL_PROJ] || cfg_cnt == 8'h00) begin
      next_link_green = 1'b0;
    end else if (resp_cnt == 8'h00) begin
      next_link_red = flash;
    end else if (resp_cnt < cfg_cnt) begin
      next_link_green = flash;
    end else begin
      next_link_green = 1'b1;
    end
  end

  // Read data mux
  always @* begin
    next_readdata = 32'h00000000;
    case (address_i)
      `SIE_ADDR_CTRL: next_readdata = ctrl;
      `SIE_ADDR_STAT: begin
        next_readdata[`SIE_STAT_STATE] = state;
        next_readdata[`SIE_STAT_REFUSED] = refused;
        next_readdata[`SIE_STAT_LOCKED] = card_locked;
        next_readdata[`SIE_STAT_PRESENT] = card_present;
        next_readdata[`SIE_STAT_LAMPS] = lamp_vec;
      end
      default: next_readdata = 32'h00000000;
    endcase
  end

  // Control register: byte lanes, card busy ends on self-reset entry
  always @* begin
    next_ctrl = ctrl;
    if (wr_ctrl) begin
      for (i = 0; i < 4; i = i + 1) begin
        if (byteenable_i[i]) begin
          next_ctrl[i*8 +: 8] = writedata_i[i*8 +: 8];
        end
      end
    end else if (next_state == ST_RST_RED && state != ST_RST_RED) begin
      next_ctrl[`SIE_CTRL_CBUSY] = 1'b0;
    end
  end

  // Phase timer, restarts on every state change
  always @* begin
    next_timer = timer;
    if (next_state != state) begin
      next_timer = {CNT_W{1'b0}};
    end else if (in_reset) begin
      next_timer = timer + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // Avalon slave handshake
  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      waitrequest_o <= 1'b1;
      readdata_o <= 32'h00000000;
    end else if (ce_i) begin
      if ((read_i | write_i) & waitrequest_o) begin
        waitrequest_o <= 1'b0;
        readdata_o <= read_i ? next_readdata : 32'h00000000;
      end else begin
        waitrequest_o <= 1'b1;
      end
    end
  end

  // Control register, sequencer and lamp outputs
  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      ctrl <= `SIE_CTRL_RST;
      state <= ST_IDLE;
      timer <= {CNT_W{1'b0}};
      refused <= 1'b0;
      health_green_o <= 1'b0;
      health_red_o <= 1'b0;
      card_green_o <= 1'b0;
      card_red_o <= 1'b0;
      mode_green_o <= 1'b0;
      override_yellow_o <= 1'b0;
      link_green_o <= 1'b0;
      link_red_o <= 1'b0;
      self_reset_o <= 1'b0;
    end else if (ce_i) begin
      ctrl <= next_ctrl;
      state <= next_state;
      refused <= next_refused;
      timer <= next_timer;
      self_reset_o <= (next_state == ST_RST_RED) |
        (next_state == ST_RST_BOOT);
      health_green_o <= next_health_green;
      health_red_o <= next_health_red;
      card_green_o <= next_card_green;
      card_red_o <= next_card_red;
      mode_green_o <= next_mode_green;
      override_yellow_o <= next_override_yellow;
      link_green_o <= next_link_green;
      link_red_o <= next_link_red;
    end
  end

endmodule

/* testbench/sie_panel_obs.sv */
module sie_panel_obs (
  input wire sys_clk_i,
  input wire clr_i,
  input wire [7:0] lamps_i,
  output reg [7:0] seen_on_o,
  output reg [7:0] seen_off_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Operator view: which levels each lamp showed since last clear
  always @(posedge sys_clk_i) begin
    if (clr_i) begin
      seen_on_o <= 8'h00;
      seen_off_o <= 8'h00;
    end else begin
      seen_on_o <= seen_on_o | lamps_i;
      seen_off_o <= seen_off_o | ~lamps_i;
    end
  end
endmodule

/* testbench/sie_lamp_encoder_chk.sv */
module sie_lamp_encoder_chk #(
  parameter [31:0] RED_CYC = 32'h8,
  parameter [31:0] BOOT_CYC = 32'h6
) (
  input wire sys_clk_i,
  input wire nrst_i,
  input wire ce_i,
  input wire [1:0] address_i,
  input wire read_i,
  input wire write_i,
  input wire [31:0] readdata_o,
  input wire waitrequest_o,
  input wire health_green_o,
  input wire health_red_o,
  input wire card_green_o,
  input wire card_red_o,
  input wire mode_green_o,
  input wire override_yellow_o,
  input wire link_green_o,
  input wire link_red_o,
  input wire self_reset_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  reg [31:0] sr_cnt;
  wire req = ce_i && (read_i || write_i);
  wire dark = !card_green_o && !card_red_o && !mode_green_o &&
    !override_yellow_o && !link_green_o && !link_red_o;
  // Length of the self-reset window
  always @(posedge sys_clk_i) begin
    if (!nrst_i) sr_cnt <= 32'h0;
    else if (self_reset_o) sr_cnt <= sr_cnt + 32'h1;
    else sr_cnt <= 32'h0;
  end
  sequence s_start;
    $rose(self_reset_o);
  endsequence
  sequence s_end;
    $fell(self_reset_o);
  endsequence
  sequence s_red;
    (health_red_o && !health_green_o) [*6];
  endsequence
  a_wait_one: assert property (!waitrequest_o |=> waitrequest_o)
    else $error("waitrequest low longer than one cycle");
  a_wait_ans: assert property ((req && waitrequest_o) |=> !waitrequest_o)
    else $error("request not answered next cycle");
  a_idle_zero: assert property (
    (read_i && !waitrequest_o && address_i[0]) |-> readdata_o == 32'h0)
    else $error("command or unmapped read not zero");
  a_reset_red: assert property (s_start |-> ##[0:1] s_red)
    else $error("no solid red at self-reset start");
  a_reset_len: assert property (
    s_end |-> sr_cnt == RED_CYC + BOOT_CYC)
    else $error("self-reset length wrong");
  a_reset_dark: assert property (
    (self_reset_o && $past(self_reset_o)) |-> dark)
    else $error("lamp lit during self-reset");
  a_boot_dark: assert property (
    s_end |-> !$past(health_green_o, 3) && !$past(health_red_o, 3))
    else $error("health lamp lit in boot phase");
  a_reset_green: assert property (s_end |-> ##[0:2]
    (health_green_o && !health_red_o && !card_green_o && !card_red_o))
    else $error("no solid green after self-reset");
  c_reset: cover property (s_start);
endmodule

bind sie_lamp_encoder sie_lamp_encoder_chk #(
  .RED_CYC(RED_CYC),
  .BOOT_CYC(BOOT_CYC)
) i_sie_lamp_encoder_chk (
  .sys_clk_i, .nrst_i, .ce_i, .address_i, .read_i, .write_i,
  .readdata_o, .waitrequest_o, .health_green_o, .health_red_o,
  .card_green_o, .card_red_o, .mode_green_o, .override_yellow_o,
  .link_green_o, .link_red_o, .self_reset_o
);

/* testbench/tb_sie_lamp_encoder.sv */
module tb_sie_lamp_encoder;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [31:0] FH = 32'h4;
  localparam [1:0] OF = 2'h1, ON = 2'h2, FL = 2'h3;
  reg clk = 1'b0, nrst = 1'b0, rd = 1'b0, wr = 1'b0, ce = 1'b1;
  reg lock = 1'b0, pres = 1'b0, clr = 1'b1;
  reg [1:0] addr = 2'h0;
  reg [3:0] be = 4'hF;
  reg [31:0] wd = 32'h0, rdat, c;
  reg [15:0] rnd = 16'h001D;
  integer bad_count = 0, n_checks = 0, i, k, n, ph;
  wire [31:0] rdo;
  wire wrq, sr;
  wire [7:0] lamps, son, soff;
  always #2 clk = ~clk;
  sie_lamp_encoder #(.FLASH_HALF_CYC(FH), .RED_CYC(32'h8),
    .BOOT_CYC(32'h6)) i_sie_lamp_encoder (
    .sys_clk_i(clk), .nrst_i(nrst), .ce_i(ce), .address_i(addr),
    .read_i(rd), .write_i(wr), .byteenable_i(be), .writedata_i(wd),
    .readdata_o(rdo), .waitrequest_o(wrq), .card_lock_i(lock),
    .card_present_i(pres), .health_green_o(lamps[7]),
    .health_red_o(lamps[6]), .card_green_o(lamps[5]),
    .card_red_o(lamps[4]), .mode_green_o(lamps[3]),
    .override_yellow_o(lamps[2]), .link_green_o(lamps[1]),
    .link_red_o(lamps[0]), .self_reset_o(sr));
  sie_panel_obs i_sie_panel_obs (.sys_clk_i(clk), .clr_i(clr),
    .lamps_i(lamps), .seen_on_o(son), .seen_off_o(soff));
  function [15:0] nx(input [15:0] s);
    nx = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Idle lamp codes: off, solid or flashing, fault first
  function [15:0] ex_idle(input [31:0] v);
    reg f;
    begin
      f = v[5] | v[6];
      ex_idle[15:14] = f ? OF : ON;
      ex_idle[13:12] = v[6] ? ON : (v[5] ? FL : OF);
      ex_idle[11:10] = (!v[8] && v[7]) ? FL : OF;
      ex_idle[9:8] = v[8] ? FL : OF;
      ex_idle[7:6] = (v[1:0] == 2'h1) ? ON : OF;
      ex_idle[5:4] = v[3] ? ON : (v[2] ? FL : OF);
      ex_idle[3:2] = (f || !v[4] || v[23:16] == 8'h00 ||
        v[31:24] == 8'h00) ? OF :
        ((v[31:24] < v[23:16]) ? FL : ON);
      ex_idle[1:0] = (f || (v[4] && v[23:16] != 8'h00 &&
        v[31:24] == 8'h00)) ? FL : OF;
    end
  endfunction
  task summarize;
    if (bad_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task tick(input integer m);
    repeat (m) @(posedge clk);
  endtask
  task bus(input w, input [1:0] a, input [31:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      k = 0;
      do begin
        @(posedge clk);
        k = k + 1;
      end while (wrq !== 1'b0 && k < 50);
      rdat = rdo;
      wr <= 1'b0;
      rd <= 1'b0;
      if (k >= 50) begin
        bad_count = bad_count + 1;
        summarize;
      end
    end
  endtask
  task look(input [15:0] exp);
    reg [15:0] got;
    begin
      tick(3);
      clr <= 1'b1;
      tick(1);
      clr <= 1'b0;
      tick(12);
      for (i = 0; i < 8; i = i + 1) got[2*i +: 2] = {son[i], soff[i]};
      chk(got, exp);
    end
  endtask
  task wait_sr(input v);
    begin
      k = 0;
      while (sr !== v && k < 100) begin
        tick(1);
        k = k + 1;
      end
      if (k >= 100) begin
        bad_count = bad_count + 1;
        summarize;
      end
    end
  endtask
  initial begin
    tick(20);
    nrst <= 1'b1;
    pres <= 1'b1;
    tick(8);
    look(ex_idle(32'h0));
    bus(1'b1, 2'h3, 32'hFFFFFFFF);
    bus(1'b0, 2'h3, 32'h0);
    chk(rdat, 32'h0);
    bus(1'b0, 2'h0, 32'h0);
    chk(rdat, 32'h0);
    for (n = 0; n < 14; n = n + 1) begin
      rnd = nx(rnd);
      c = {6'h00, rnd[15:14], 6'h00, rnd[13:12], 7'h00, rnd[8:2],
        (rnd[1:0] == 2'h3) ? 2'h2 : rnd[1:0]};
      bus(1'b1, 2'h0, c);
      bus(1'b0, 2'h0, 32'h0);
      chk(rdat, c);
      look(ex_idle(c));
    end
    be <= 4'h1;
    bus(1'b1, 2'h0, ~c);
    be <= 4'hF;
    bus(1'b0, 2'h0, 32'h0);
    chk(rdat, {c[31:8], ~c[7:0]});
    bus(1'b1, 2'h0, 32'h00000080);
    bus(1'b1, 2'h1, 32'h1);
    bus(1'b1, 2'h1, 32'h2);
    bus(1'b0, 2'h2, 32'h0);
    chk(rdat[2:0], 32'h1);
    look({FL, OF, FL, OF, OF, OF, OF, OF});
    ph = 0;
    repeat (10) begin
      tick(1);
      if (lamps[7] !== lamps[5]) ph = 1;
    end
    chk(ph, 32'h0);
    ce <= 1'b0;
    tick(2);
    c = {23'h0, sr, lamps};
    ph = 0;
    repeat (12) begin
      tick(1);
      if ({sr, lamps} !== c[8:0]) ph = 1;
    end
    ce <= 1'b1;
    chk(ph, 32'h0);
    bus(1'b1, 2'h1, 32'h4);
    wait_sr(1'b1);
    wait_sr(1'b0);
    look(ex_idle(32'h0));
    bus(1'b0, 2'h0, 32'h0);
    chk(rdat, 32'h0);
    for (n = 0; n < 4; n = n + 1) begin
      lock <= (n == 1 || n == 3);
      pres <= (n != 2);
      tick(8);
      bus(1'b1, 2'h0, (n == 0) ? 32'h1 : 32'h0);
      bus(1'b1, 2'h1, (n >= 2) ? 32'h2 : 32'h1);
      bus(1'b0, 2'h2, 32'h0);
      chk(rdat[2:0], (n == 3) ? 32'h2 : 32'h0);
    end
    chk(rdat[5:3], 32'h7);
    bus(1'b1, 2'h2, 32'h8);
    look({FL, OF, FL, OF, OF, OF, OF, OF});
    bus(1'b1, 2'h1, 32'h4);
    wait_sr(1'b1);
    bus(1'b1, 2'h1, 32'h1);
    bus(1'b0, 2'h2, 32'h0);
    chk(rdat[3:0], 32'h3);
    wait_sr(1'b0);
    look(ex_idle(32'h0));
    bus(1'b0, 2'h2, 32'h0);
    chk(rdat[2:0], 32'h0);
    bus(1'b1, 2'h0, 32'h0000000C);
    nrst <= 1'b0;
    tick(2);
    chk({22'h0, wrq, sr, lamps}, 32'h200);
    chk(rdo, 32'h0);
    nrst <= 1'b1;
    tick(8);
    bus(1'b0, 2'h0, 32'h0);
    chk(rdat, 32'h0);
    look(ex_idle(32'h0));
    summarize;
  end
endmodule
